//--- logic/irq_flag_pkg.sv
// Package for the interrupt request flag bank: offsets, masks, reset values and carriers.
// Assumes one clock domain; every user names items as irq_flag_pkg::name.
`default_nettype none

package irq_flag_pkg;

   // ************************************************************
   // Sizes and register map
   // ************************************************************
   localparam int unsigned NUM_REGS = 4;
   localparam int unsigned FLAG_W   = 16;
   localparam int unsigned ADDR_W   = 4;
   localparam int unsigned EVT_W    = 8;

   localparam logic [3:0] OFS_FLAGS_0    = 4'h0;
   localparam logic [3:0] OFS_FLAGS_1    = 4'h1;
   localparam logic [3:0] OFS_FLAGS_2    = 4'h2;
   localparam logic [3:0] OFS_FLAGS_3    = 4'h3;
   localparam logic [3:0] OFS_EVT_STATUS = 4'h4;
   localparam logic [3:0] OFS_EVT_MASK   = 4'h5;

   // ************************************************************
   // Implemented bits and reset values
   // ************************************************************
   localparam logic [15:0] IMPL_FLAGS_0 = 16'h0007;
   localparam logic [15:0] IMPL_FLAGS_1 = 16'hFFFB;
   localparam logic [15:0] IMPL_FLAGS_2 = 16'hDFFF;
   localparam logic [15:0] IMPL_FLAGS_3 = 16'hA7FF;
   localparam logic [15:0] RST_FLAGS    = 16'h0000;
   localparam logic [7:0]  RST_EVT      = 8'h00;
   localparam logic [15:0] READ_ZERO    = 16'h0000;

   // Event status layout: new request per register, then repeat request per register.
   localparam int unsigned EVT_NEW_LSB = 0;
   localparam int unsigned EVT_REP_LSB = 4;

   // ************************************************************
   // Flag register layouts
   // ************************************************************
   typedef struct packed {
      logic [12:0] unused_hi;
      logic        ocmp1_req_flag;
      logic        icap1_req_flag;
      logic        ext_pin0_req_flag;
   } flags_0_t;

   typedef struct packed {
      logic uart2_tx_req_flag;
      logic uart2_rx_req_flag;
      logic ext_pin2_req_flag;
      logic timer5_req_flag;
      logic timer4_req_flag;
      logic ocmp4_req_flag;
      logic ocmp3_req_flag;
      logic dma_ch2_done_flag;
      logic icap8_req_flag;
      logic icap7_req_flag;
      logic adc2_done_flag;
      logic ext_pin1_req_flag;
      logic change_notify_flag;
      logic unused_b2;
      logic i2c1_master_evt_flag;
      logic i2c1_slave_evt_flag;
   } flags_1_t;

   typedef struct packed {
      logic timer6_req_flag;
      logic dma_ch4_done_flag;
      logic unused_b13;
      logic ocmp8_req_flag;
      logic ocmp7_req_flag;
      logic ocmp6_req_flag;
      logic ocmp5_req_flag;
      logic icap6_req_flag;
      logic icap5_req_flag;
      logic icap4_req_flag;
      logic icap3_req_flag;
      logic dma_ch3_done_flag;
      logic can1_event_flag;
      logic can1_rx_ready_flag;
      logic spi2_event_flag;
      logic spi2_error_flag;
   } flags_2_t;

   typedef struct packed {
      logic       pwm_fault_a_flag;
      logic       unused_b14;
      logic       dma_ch5_done_flag;
      logic [1:0] unused_b12_11;
      logic       quad_encoder_evt_flag;
      logic       pwm_error_flag;
      logic       can2_event_flag;
      logic       can2_rx_ready_flag;
      logic       ext_pin4_req_flag;
      logic       ext_pin3_req_flag;
      logic       timer9_req_flag;
      logic       timer8_req_flag;
      logic       i2c2_master_evt_flag;
      logic       i2c2_slave_evt_flag;
      logic       timer7_req_flag;
   } flags_3_t;

   // Register 0 sits in the low word so the bank casts to an array of words.
   typedef struct packed {
      flags_3_t r3;
      flags_2_t r2;
      flags_1_t r1;
      flags_0_t r0;
   } flag_bank_t;

   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } bus_req_t;

   typedef struct packed {
      logic [7:0]  evt_status;
      logic [7:0]  evt_mask;
      logic [15:0] rdata;
      logic        irq;
   } bank_state_t;

   typedef struct packed {
      logic [15:0] flags;
   } flag_reg_state_t;

endpackage

`default_nettype wire

//--- logic/irq_flag_reg.sv
// One 16-bit interrupt request flag register with a mask of implemented bits.
// Assumes set pulses and the write come from logic on ref_clk.
`timescale 1ns/1ps
`default_nettype none

module irq_flag_reg
#(
   parameter logic [15:0] IMPL = 16'hFFFF
)
(
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic [15:0] set,
   input  wire logic        wr_en,
   input  wire logic [15:0] wdata,
   output logic      [15:0] flags,
   output logic             new_req,
   output logic             rep_req
);

   irq_flag_pkg::flag_reg_state_t state;
   irq_flag_pkg::flag_reg_state_t next_state;
   logic [15:0]                   set_impl;

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb
   begin
      set_impl   = set & IMPL;
      next_state = state;
      if (wr_en)
      begin
         next_state.flags = wdata & IMPL;
      end
      // A request in the same cycle as a software clear still lands.
      next_state.flags = next_state.flags | set_impl;
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state.flags <= irq_flag_pkg::RST_FLAGS;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign flags   = state.flags;
   assign new_req = |(set_impl & ~state.flags);
   assign rep_req = |(set_impl & state.flags);

endmodule // irq_flag_reg

`default_nettype wire

//--- logic/interrupt_flag_status_bank.sv
// Bank of four interrupt request flag registers with an event status, mask and interrupt.
// Assumes request pulses from on-chip peripherals on ref_clk and a one-cycle strobe bus.
//
// Overview of operation
// - Register 0: output compare 1 at bit 2, capture 1 bit 1, pin 0 bit 0.
// - Register 1 bits 15..8: UART2 tx/rx, pin 2, timers 5,4, compares 4,3, DMA 2.
// - Register 1 bits 7..0: captures 8,7, ADC2, pin 1, change notify, gap, I2C1.
// - Register 2 bits 15..8: timer 6, DMA 4, gap, compares 8..5, capture 6.
// - Register 2 bits 7..0: captures 5..3, DMA 3, CAN1 event/receive, SPI2 event/error.
// - Register 3: fault A 15, DMA 5 13, encoder 10, PWM error 9, CAN2 8.
// - Register 3 bits 7..0: CAN2 receive, pins 4,3, timers 9,8, I2C2, timer 7.
// - A flag reads one after its request, zero until a new request after clearing.
// - Every implemented flag is software readable and writable and resets to zero.
// - Unimplemented positions read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none

module interrupt_flag_status_bank
(
   input  wire logic                    ref_clk,
   input  wire logic                    nrst,
   input  wire irq_flag_pkg::bus_req_t  bus,
   input  wire irq_flag_pkg::flag_bank_t req,
   output logic                  [15:0] rdata,
   output logic                         irq,
   output irq_flag_pkg::flag_bank_t     flags
);

   // ************************************************************
   // Decoding helpers
   // ************************************************************
   function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
      hit = (addr == ofs);
   endfunction

   function automatic logic [15:0] impl_mask(input int unsigned idx);
      case (idx)
         0: impl_mask = irq_flag_pkg::IMPL_FLAGS_0;
         1: impl_mask = irq_flag_pkg::IMPL_FLAGS_1;
         2: impl_mask = irq_flag_pkg::IMPL_FLAGS_2;
         default: impl_mask = irq_flag_pkg::IMPL_FLAGS_3;
      endcase
   endfunction

   function automatic logic [3:0] flag_ofs(input int unsigned idx);
      case (idx)
         0: flag_ofs = irq_flag_pkg::OFS_FLAGS_0;
         1: flag_ofs = irq_flag_pkg::OFS_FLAGS_1;
         2: flag_ofs = irq_flag_pkg::OFS_FLAGS_2;
         default: flag_ofs = irq_flag_pkg::OFS_FLAGS_3;
      endcase
   endfunction

   // ************************************************************
   // Request routing into register layout
   // ************************************************************
   irq_flag_pkg::flag_bank_t set_bank;
   logic [3:0][15:0]         set_words;
   logic [3:0][15:0]         flag_words;
   logic [3:0]               wr_flag;
   logic [3:0]               new_req;
   logic [3:0]               rep_req;

   always_comb
   begin
      set_bank = '0;
      set_bank.r0.ocmp1_req_flag        = req.r0.ocmp1_req_flag;
      set_bank.r0.icap1_req_flag        = req.r0.icap1_req_flag;
      set_bank.r0.ext_pin0_req_flag     = req.r0.ext_pin0_req_flag;
      set_bank.r1.uart2_tx_req_flag     = req.r1.uart2_tx_req_flag;
      set_bank.r1.uart2_rx_req_flag     = req.r1.uart2_rx_req_flag;
      set_bank.r1.ext_pin2_req_flag     = req.r1.ext_pin2_req_flag;
      set_bank.r1.timer5_req_flag       = req.r1.timer5_req_flag;
      set_bank.r1.timer4_req_flag       = req.r1.timer4_req_flag;
      set_bank.r1.ocmp4_req_flag        = req.r1.ocmp4_req_flag;
      set_bank.r1.ocmp3_req_flag        = req.r1.ocmp3_req_flag;
      set_bank.r1.dma_ch2_done_flag     = req.r1.dma_ch2_done_flag;
      set_bank.r1.icap8_req_flag        = req.r1.icap8_req_flag;
      set_bank.r1.icap7_req_flag        = req.r1.icap7_req_flag;
      set_bank.r1.adc2_done_flag        = req.r1.adc2_done_flag;
      set_bank.r1.ext_pin1_req_flag     = req.r1.ext_pin1_req_flag;
      set_bank.r1.change_notify_flag    = req.r1.change_notify_flag;
      set_bank.r1.i2c1_master_evt_flag  = req.r1.i2c1_master_evt_flag;
      set_bank.r1.i2c1_slave_evt_flag   = req.r1.i2c1_slave_evt_flag;
      set_bank.r2.timer6_req_flag       = req.r2.timer6_req_flag;
      set_bank.r2.dma_ch4_done_flag     = req.r2.dma_ch4_done_flag;
      set_bank.r2.ocmp8_req_flag        = req.r2.ocmp8_req_flag;
      set_bank.r2.ocmp7_req_flag        = req.r2.ocmp7_req_flag;
      set_bank.r2.ocmp6_req_flag        = req.r2.ocmp6_req_flag;
      set_bank.r2.ocmp5_req_flag        = req.r2.ocmp5_req_flag;
      set_bank.r2.icap6_req_flag        = req.r2.icap6_req_flag;
      set_bank.r2.icap5_req_flag        = req.r2.icap5_req_flag;
      set_bank.r2.icap4_req_flag        = req.r2.icap4_req_flag;
      set_bank.r2.icap3_req_flag        = req.r2.icap3_req_flag;
      set_bank.r2.dma_ch3_done_flag     = req.r2.dma_ch3_done_flag;
      set_bank.r2.can1_event_flag       = req.r2.can1_event_flag;
      set_bank.r2.can1_rx_ready_flag    = req.r2.can1_rx_ready_flag;
      set_bank.r2.spi2_event_flag       = req.r2.spi2_event_flag;
      set_bank.r2.spi2_error_flag       = req.r2.spi2_error_flag;
      set_bank.r3.pwm_fault_a_flag      = req.r3.pwm_fault_a_flag;
      set_bank.r3.dma_ch5_done_flag     = req.r3.dma_ch5_done_flag;
      set_bank.r3.quad_encoder_evt_flag = req.r3.quad_encoder_evt_flag;
      set_bank.r3.pwm_error_flag        = req.r3.pwm_error_flag;
      set_bank.r3.can2_event_flag       = req.r3.can2_event_flag;
      set_bank.r3.can2_rx_ready_flag    = req.r3.can2_rx_ready_flag;
      set_bank.r3.ext_pin4_req_flag     = req.r3.ext_pin4_req_flag;
      set_bank.r3.ext_pin3_req_flag     = req.r3.ext_pin3_req_flag;
      set_bank.r3.timer9_req_flag       = req.r3.timer9_req_flag;
      set_bank.r3.timer8_req_flag       = req.r3.timer8_req_flag;
      set_bank.r3.i2c2_master_evt_flag  = req.r3.i2c2_master_evt_flag;
      set_bank.r3.i2c2_slave_evt_flag   = req.r3.i2c2_slave_evt_flag;
      set_bank.r3.timer7_req_flag       = req.r3.timer7_req_flag;
   end

   assign set_words = set_bank;

   // ************************************************************
   // Flag registers
   // ************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_flag
         assign wr_flag[gi] = bus.wr && hit(bus.addr, flag_ofs(gi));

         irq_flag_reg
         #(
            .IMPL (impl_mask(gi))
         )
         u_flag
         (
            .ref_clk (ref_clk),
            .nrst    (nrst),
            .set     (set_words[gi]),
            .wr_en   (wr_flag[gi]),
            .wdata   (bus.wdata),
            .flags   (flag_words[gi]),
            .new_req (new_req[gi]),
            .rep_req (rep_req[gi])
         );
      end
   endgenerate

   assign flags = flag_words;

   // ************************************************************
   // Event status, mask, read data and interrupt
   // ************************************************************
   irq_flag_pkg::bank_state_t state;
   irq_flag_pkg::bank_state_t next_state;
   logic [7:0]                events;
   logic [7:0]                clr_bits;

   always_comb
   begin
      events = '0;
      events[irq_flag_pkg::EVT_NEW_LSB +: 4] = new_req;
      events[irq_flag_pkg::EVT_REP_LSB +: 4] = rep_req;
      clr_bits = '0;
      if (bus.wr && hit(bus.addr, irq_flag_pkg::OFS_EVT_STATUS))
      begin
         clr_bits = bus.wdata[7:0];
      end
      next_state = state;
      // Write one to clear; an event in the same cycle keeps its bit set.
      next_state.evt_status = (state.evt_status & ~clr_bits) | events;
      if (bus.wr && hit(bus.addr, irq_flag_pkg::OFS_EVT_MASK))
      begin
         next_state.evt_mask = bus.wdata[7:0];
      end
      next_state.irq = |(next_state.evt_status & next_state.evt_mask);
      // Read data stand for one cycle only; unmapped addresses read zero.
      next_state.rdata = irq_flag_pkg::READ_ZERO;
      if (bus.rd)
      begin
         case (bus.addr)
            irq_flag_pkg::OFS_FLAGS_0:    next_state.rdata = flag_words[0];
            irq_flag_pkg::OFS_FLAGS_1:    next_state.rdata = flag_words[1];
            irq_flag_pkg::OFS_FLAGS_2:    next_state.rdata = flag_words[2];
            irq_flag_pkg::OFS_FLAGS_3:    next_state.rdata = flag_words[3];
            irq_flag_pkg::OFS_EVT_STATUS: next_state.rdata = {8'h00, state.evt_status};
            irq_flag_pkg::OFS_EVT_MASK:   next_state.rdata = {8'h00, state.evt_mask};
            default:                      next_state.rdata = irq_flag_pkg::READ_ZERO;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state.evt_status <= irq_flag_pkg::RST_EVT;
         state.evt_mask   <= irq_flag_pkg::RST_EVT;
         state.rdata      <= irq_flag_pkg::READ_ZERO;
         state.irq        <= 1'b0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign rdata = state.rdata;
   assign irq   = state.irq;

endmodule // interrupt_flag_status_bank

`default_nettype wire

//--- verification/irq_flag_bank_chk_sva.sv
// Concurrent checks for the interrupt request flag bank.
// Assumes it is bound to interrupt_flag_status_bank and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module irq_flag_bank_chk
(
   input wire logic                     ref_clk,
   input wire logic                     nrst,
   input wire irq_flag_pkg::bus_req_t   bus,
   input wire irq_flag_pkg::flag_bank_t req,
   input wire logic              [15:0] rdata,
   input wire logic                     irq,
   input wire irq_flag_pkg::flag_bank_t flags
);
   // ************************************************************
   // Helpers
   // ************************************************************
   // The implemented map is written out here so a wrong package mask is caught.
   logic [63:0] impl_all;
   logic [63:0] flag_vec;
   logic [63:0] req_impl;
   logic [15:0] sel_word;
   logic [15:0] sel_mask;
   logic [15:0] req_word;
   logic [15:0] wr_seen;
   logic [1:0]  wr_idx;
   logic [15:0] wr_exp;
   logic        irq_src;

   assign impl_all = 64'hA7FF_DFFF_FFFB_0007;
   assign flag_vec = flags;
   assign req_impl = req & impl_all;
   assign sel_word = flag_vec[bus.addr[1:0]*16 +: 16];
   assign sel_mask = impl_all[bus.addr[1:0]*16 +: 16];
   assign req_word = req_impl[bus.addr[1:0]*16 +: 16];
   assign wr_seen  = flag_vec[wr_idx*16 +: 16];
   assign wr_exp   = bus.wdata & sel_mask;
   assign irq_src  = (req != 64'h0) || bus.wr;

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         wr_idx <= 2'h0;
      else
         wr_idx <= bus.addr[1:0];
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   // ************************************************************
   // Assertions
   // ************************************************************
   rd_idle_a: assert property (!bus.rd |=> rdata == 16'h0000)
      else $error("read data not zero outside a read");
   rd_word_a: assert property (
      bus.rd && bus.addr < 4'h4 && req_impl == 64'h0 |=> rdata == $past(sel_word))
      else $error("read data differs from flag register");
   unmapped_rd_a: assert property (bus.rd && bus.addr > 4'h5 |=> rdata == 16'h0000)
      else $error("unmapped read returned data");
   gap_zero_a: assert property ((flag_vec & ~impl_all) == 64'h0)
      else $error("unimplemented flag position set");
   req_sets_a: assert property (
      req_impl != 64'h0 |=> (flag_vec & $past(req_impl)) == $past(req_impl))
      else $error("request did not set its flag");
   flag_hold_a: assert property (req_impl == 64'h0 && !bus.wr |=> $stable(flags))
      else $error("flags changed without request or write");
   wr_store_a: assert property (
      bus.wr && bus.addr < 4'h4 && req_impl == 64'h0 |=> wr_seen == $past(wr_exp))
      else $error("flag write not stored");
   set_wins_a: assert property (
      bus.wr && bus.addr < 4'h4 && bus.wdata == 16'h0000 |=> wr_seen == $past(req_word))
      else $error("request lost against a clearing write");
   irq_cause_a: assert property ($rose(irq) |-> $past(irq_src))
      else $error("interrupt rose without a cause");

   req_cover_c: cover property (req_impl != 64'h0 ##1 bus.rd);
   clash_cover_c: cover property (bus.wr && bus.wdata == 16'h0000 && req_word != 16'h0000);
   irq_cover_c: cover property ($rose(irq));

endmodule // irq_flag_bank_chk

bind interrupt_flag_status_bank irq_flag_bank_chk u_chk
(
   .ref_clk (ref_clk),
   .nrst    (nrst),
   .bus     (bus),
   .req     (req),
   .rdata   (rdata),
   .irq     (irq),
   .flags   (flags)
);

`default_nettype wire

//--- verification/irq_source_model.sv
// Model of the peripheral request sources: one-cycle request pulses on ref_clk.
// Assumes the bench calls fire between edges; the pulse starts after an optional lag.
`timescale 1ns/1ps
`default_nettype none

module irq_source_model
(
   input  wire logic                    ref_clk,
   output var irq_flag_pkg::flag_bank_t req
);
   initial req = '0;

   // A lag lets a source answer promptly or slowly relative to the caller.
   task automatic fire(input irq_flag_pkg::flag_bank_t v, input int unsigned lag);
      repeat (lag) @(posedge ref_clk);
      @(posedge ref_clk);
      req <= v;
      @(posedge ref_clk);
      req <= '0;
      #1;
   endtask

endmodule // irq_source_model

`default_nettype wire

//--- verification/test_interrupt_flag_status_bank.sv
// Self-checking bench for the interrupt request flag bank.
// Assumes the checker is bound in and the source model drives the request pulses.
`timescale 1ns/1ps
`default_nettype none

module test_interrupt_flag_status_bank;
   logic                     ref_clk;
   logic                     nrst;
   irq_flag_pkg::bus_req_t   bus;
   irq_flag_pkg::flag_bank_t req;
   irq_flag_pkg::flag_bank_t flags_seen;
   irq_flag_pkg::flag_bank_t v;
   logic              [63:0] vec;
   logic              [63:0] flags_vec;
   logic              [15:0] rdata;
   logic                     irq;
   logic              [15:0] impl_tab [0:3] = '{16'h0007, 16'hFFFB, 16'hDFFF, 16'hA7FF};
   int                       num_errors = 0;
   int                       checks = 0;

   assign flags_vec = flags_seen;

   interrupt_flag_status_bank u_dut (.ref_clk(ref_clk), .nrst(nrst), .bus(bus), .req(req),
                                     .rdata(rdata), .irq(irq), .flags(flags_seen));
   irq_source_model u_src (.ref_clk(ref_clk), .req(req));

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      bus <= '0;
      #1;
   endtask

   // Read data stand only in the cycle after the strobe, so they are checked there.
   task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge ref_clk);
      bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      bus <= '0;
      #1;
      chk(rdata, exp);
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ************************************************************
   // Clock, watchdog and tests
   // ************************************************************
   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   initial
   begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      wrap_up();
   end

   initial
   begin
      nrst = 1'b0;
      bus  = '0;
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      for (int r = 0; r < 6; r++)
         reg_rd(r[3:0], 16'h0000);
      chk({15'h0000, irq}, 16'h0000);
      $display("test reset done");

      v = '0;
      v.r0.ocmp1_req_flag = 1'b1;
      v.r0.ext_pin0_req_flag = 1'b1;
      v.r1.uart2_tx_req_flag = 1'b1;
      v.r1.dma_ch2_done_flag = 1'b1;
      v.r1.icap8_req_flag = 1'b1;
      v.r1.i2c1_slave_evt_flag = 1'b1;
      v.r2.timer6_req_flag = 1'b1;
      v.r2.icap6_req_flag = 1'b1;
      v.r2.icap5_req_flag = 1'b1;
      v.r2.spi2_error_flag = 1'b1;
      v.r3.pwm_fault_a_flag = 1'b1;
      v.r3.dma_ch5_done_flag = 1'b1;
      v.r3.quad_encoder_evt_flag = 1'b1;
      v.r3.can2_event_flag = 1'b1;
      v.r3.can2_rx_ready_flag = 1'b1;
      v.r3.timer7_req_flag = 1'b1;
      u_src.fire(v, 0);
      reg_rd(4'h0, 16'h0005);
      reg_rd(4'h1, 16'h8181);
      reg_rd(4'h2, 16'h8181);
      reg_rd(4'h3, 16'hA581);
      $display("test named map done");

      // Every position is pulsed alone; gaps must stay clear and flags must stick.
      for (int r = 0; r < 4; r++)
         for (int b = 0; b < 16; b++)
         begin
            reg_wr(r[3:0], 16'h0000);
            vec = 64'h0;
            vec[r*16+b] = 1'b1;
            u_src.fire(vec, b % 2);
            reg_rd(r[3:0], impl_tab[r] & (16'h0001 << b));
            reg_wr(r[3:0], 16'h0000);
            reg_rd(r[3:0], 16'h0000);
         end
      $display("test bit walk done");

      for (int r = 0; r < 4; r++)
      begin
         reg_wr(r[3:0], 16'hFFFF);
         reg_rd(r[3:0], impl_tab[r]);
         chk(flags_vec[r*16 +: 16], impl_tab[r]);
         reg_wr(r[3:0], 16'h0000);
      end
      for (int a = 6; a < 16; a++)
      begin
         reg_wr(a[3:0], 16'hFFFF);
         reg_rd(a[3:0], 16'h0000);
      end
      $display("test write access done");

      v = '0;
      v.r1.timer5_req_flag = 1'b1;
      fork
         reg_wr(4'h1, 16'h0000);
         u_src.fire(v, 0);
      join
      reg_rd(4'h1, 16'h1000);
      $display("test set wins done");

      reg_wr(4'h4, 16'h00FF);
      reg_wr(4'h5, 16'h0002);
      v = '0;
      v.r1.timer4_req_flag = 1'b1;
      u_src.fire(v, 1);
      chk({15'h0000, irq}, 16'h0001);
      u_src.fire(v, 0);
      reg_rd(4'h4, 16'h0022);
      reg_wr(4'h5, 16'h0000);
      chk({15'h0000, irq}, 16'h0000);
      reg_wr(4'h5, 16'h0002);
      chk({15'h0000, irq}, 16'h0001);
      reg_wr(4'h4, 16'h0002);
      chk({15'h0000, irq}, 16'h0000);
      reg_rd(4'h4, 16'h0020);
      reg_rd(4'h1, 16'h1800);
      $display("test interrupt done");

      // A repeat request that lands with a status clear keeps its status bit.
      v = '0;
      v.r1.timer5_req_flag = 1'b1;
      fork
         reg_wr(4'h4, 16'h00FF);
         u_src.fire(v, 0);
      join
      reg_rd(4'h4, 16'h0020);
      $display("test status clear clash done");

      // A reset in mid-run must clear register 1 flags and the interrupt at once; status and mask are read after release.
      reg_wr(4'h5, 16'h0020);
      chk({15'h0000, irq}, 16'h0001);
      @(posedge ref_clk);
      nrst <= 1'b0;
      @(posedge ref_clk);
      #1;
      chk(flags_vec[31:16], 16'h0000);
      chk({15'h0000, irq}, 16'h0000);
      @(posedge ref_clk);
      nrst <= 1'b1;
      reg_rd(4'h1, 16'h0000);
      reg_rd(4'h4, 16'h0000);
      reg_rd(4'h5, 16'h0000);
      $display("test mid-run reset done");
      wrap_up();
   end

endmodule // test_interrupt_flag_status_bank

`default_nettype wire
